/* File: bench/ctm_monitor.sv */
/*
 * Port checker for the compact timer: bus answer timing, read-data
 * widths and pin routing through the pin-select register.
 * Assumes the default pin-select variant and a classic Wishbone master.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ctm_defs.vh"

module ctm_monitor (
   // System
   input wire clk_i,
   input wire rst_i,
   // Wishbone
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   input wire [31:0] dat_o,
   input wire ack_o,
   // Pins
   input wire [1:0] alt_out_i,
   input wire [1:0] alt_oe_i,
   input wire timer0_output_pin0_o,
   input wire timer0_output_pin0_oe_o,
   input wire timer0_output_pin1_o,
   input wire timer0_output_pin1_oe_o,
   input wire [3:0] timer1_pin_en_o
);
   // ---------------------------------------------------------------
   // Shadow of the pin-select register
   // ---------------------------------------------------------------
   reg [7:0] psel_q;
   wire take = cyc_i && stb_i && !ack_o;
   always @(posedge clk_i) begin
      if (rst_i)
         psel_q <= `CTM_PSEL_RST_F;
      else if (take && we_i && sel_i[0] && adr_i == `CTM_OFS_PIN_SEL)
         psel_q <= dat_i[7:0] & `CTM_PSEL_MASK_F;
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req; cyc_i && stb_i && !ack_o; endsequence
   sequence s_ans; ack_o ##1 !ack_o; endsequence
   wire rd_ack = ack_o && !we_i;
   property p_ack; s_req |=> s_ans; endproperty
   property p_rd_top; rd_ack |-> dat_o[31:8] == 24'h000000; endproperty
   property p_psel_rd;
      rd_ack && adr_i == `CTM_OFS_PIN_SEL |-> dat_o[7:0] == psel_q;
   endproperty
   property p_hi_rd;
      rd_ack && (adr_i == `CTM_OFS_CNT_HI || adr_i == `CTM_OFS_CMP_HI)
         |-> dat_o[7:2] == 6'h00;
   endproperty
   property p_en1; timer1_pin_en_o == psel_q[7:4]; endproperty
   property p_oe0; psel_q[0] |-> timer0_output_pin0_oe_o; endproperty
   property p_oe1; psel_q[1] |-> timer0_output_pin1_oe_o; endproperty
   property p_alt0;
      !psel_q[0] |-> timer0_output_pin0_oe_o == alt_oe_i[0] &&
         timer0_output_pin0_o == alt_out_i[0];
   endproperty
   property p_alt1;
      !psel_q[1] |-> timer0_output_pin1_oe_o == alt_oe_i[1] &&
         timer0_output_pin1_o == alt_out_i[1];
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle");
   a_rd_top: assert property (p_rd_top) else $error("upper bits set");
   a_psel_rd: assert property (p_psel_rd) else $error("pin sel read");
   a_hi_rd: assert property (p_hi_rd) else $error("high byte wide");
   a_en1: assert property (p_en1) else $error("timer1 enables");
   a_oe0: assert property (p_oe0) else $error("pin0 not driven");
   a_oe1: assert property (p_oe1) else $error("pin1 not driven");
   a_alt0: assert property (p_alt0) else $error("pin0 not shared");
   a_alt1: assert property (p_alt1) else $error("pin1 not shared");
endmodule // ctm_monitor

bind ctm_timer ctm_monitor i_ctm_monitor (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
   .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .alt_out_i(alt_out_i),
   .alt_oe_i(alt_oe_i), .timer0_output_pin0_o(timer0_output_pin0_o),
   .timer0_output_pin0_oe_o(timer0_output_pin0_oe_o),
   .timer0_output_pin1_o(timer0_output_pin1_o),
   .timer0_output_pin1_oe_o(timer0_output_pin1_oe_o),
   .timer1_pin_en_o(timer1_pin_en_o));
`default_nettype wire

/* File: bench/tb_top.sv */
/*
 * Self-checking bench of the compact timer: register access, the buffered
 * compare pair, period events, interrupt and clock disconnect.
 * Assumes the default pin-select variant and a one-cycle bus answer.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ctm_defs.vh"

module tb_top;
   reg clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   reg [7:0] adr_i = 8'h00;
   reg [3:0] sel_i = 4'h0;
   reg [31:0] dat_i = 32'h00000000;
   reg tick = 1'b0, ext = 1'b0;
   reg [1:0] alt_out = 2'h0, alt_oe = 2'h0;
   wire [31:0] dat_o;
   wire ack_o, p0, p0e, p1, p1e, irq_o;
   wire [3:0] t1en;
   integer errors = 0, n_compared = 0, cyc_n = 0;
   logic [31:0] exp_q[$];
   reg [9:0] r;

   always #5 clk_i = ~clk_i;

   ctm_timer i_ctm_timer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tbc_tick_i(tick),
      .timer0_ext_clock_pin_i(ext), .alt_out_i(alt_out), .alt_oe_i(alt_oe),
      .timer0_output_pin0_o(p0), .timer0_output_pin0_oe_o(p0e),
      .timer0_output_pin1_o(p1), .timer0_output_pin1_oe_o(p1e),
      .timer1_pin_en_o(t1en), .irq_o(irq_o));

   // ---------------------------------------------------------------
   // Checking and closing
   // ---------------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task end_sim;
      if (errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Bus master
   // ---------------------------------------------------------------
   task bus(input reg w, input reg [7:0] a, input reg [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w;
      adr_i <= a; dat_i <= d; sel_i <= 4'hF;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
   endtask
   task wr(input reg [7:0] a, input reg [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rd(input reg [7:0] a, input reg [31:0] exp);
      exp_q.push_back(exp);
      bus(1'b0, a, 32'h00000000);
   endtask
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0 && !rst_i)
         chk(dat_o, exp_q.pop_front());
   end
   // Shared pin traffic and watchdog
   always @(posedge clk_i) begin
      alt_out <= $urandom;
      alt_oe <= $urandom;
      ext <= $urandom;
      cyc_n++;
      if (cyc_n > 5000) begin
         errors++;
         end_sim;
      end
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'h0e0e));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`CTM_OFS_PIN_SEL, {24'h0, `CTM_PSEL_RST_F});
      rd(`CTM_OFS_CTRL0, 32'h0);
      wr(`CTM_OFS_PIN_SEL, 32'hFF);
      rd(`CTM_OFS_PIN_SEL, {24'h0, `CTM_PSEL_MASK_F});
      chk({28'h0, t1en}, 32'hF);
      wr(`CTM_OFS_PIN_SEL, 32'h0);
      rd(`CTM_OFS_PIN_SEL, 32'h0);
      r = $urandom | 10'h200;
      wr(`CTM_OFS_CMP_LO, {24'h0, r[7:0]});
      rd(`CTM_OFS_CMP_HI, 32'h0);
      rd(`CTM_OFS_CMP_LO, 32'h0);
      wr(`CTM_OFS_CMP_LO, {24'h0, r[7:0]});
      wr(`CTM_OFS_CMP_HI, {30'h0, r[9:8]});
      rd(`CTM_OFS_CMP_HI, {30'h0, r[9:8]});
      rd(`CTM_OFS_CMP_LO, {24'h0, r[7:0]});
      rd(8'h3C, 32'h0);
      // Period one, system clock, duty beyond the period
      wr(`CTM_OFS_INT_MASK, 32'h2);
      wr(`CTM_OFS_CTRL0, 32'h19);
      repeat (140) @(posedge clk_i);
      wr(`CTM_OFS_CTRL0, 32'h99);
      rd(`CTM_OFS_INT_STAT, 32'h2);
      chk({31'h0, irq_o}, 32'h1);
      rd(`CTM_OFS_CNT_HI, 32'h0);
      wr(`CTM_OFS_INT_STAT, 32'h2);
      rd(`CTM_OFS_INT_STAT, 32'h0);
      chk({31'h0, irq_o}, 32'h0);
      // Masked event
      wr(`CTM_OFS_INT_MASK, 32'h0);
      wr(`CTM_OFS_CTRL0, 32'h19);
      repeat (140) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
      rd(`CTM_OFS_INT_STAT, 32'h2);
      // Disconnected clock source
      wr(`CTM_OFS_CTRL0, 32'h59);
      wr(`CTM_OFS_INT_STAT, 32'h3);
      repeat (200) @(posedge clk_i);
      rd(`CTM_OFS_INT_STAT, 32'h0);
      // Compare output mode: initial level on pin0, then inverted
      wr(`CTM_OFS_PIN_SEL, 32'h1);
      wr(`CTM_OFS_CTRL1, 32'h38);
      wr(`CTM_OFS_CTRL0, 32'h00);
      wr(`CTM_OFS_CTRL0, 32'h58);
      @(posedge clk_i);
      chk({31'h0, p0}, 32'h1);
      chk({31'h0, p0e}, 32'h1);
      wr(`CTM_OFS_OUT_INV, 32'h1);
      chk({31'h0, p0}, 32'h0);
      end_sim;
   end
endmodule // tb_top
`default_nettype wire

/* File: design/ctm_defs.vh */
/*
 * Constants of the compact timer: register offsets, field positions,
 * reset values and divider counts.
 * Assumes a 32-bit Wishbone register bus with byte addresses.
 */
`ifndef CTM_DEFS_VH
`define CTM_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CTM_OFS_CTRL0     8'h00
`define CTM_OFS_CTRL1     8'h04
`define CTM_OFS_CNT_LO    8'h08
`define CTM_OFS_CNT_HI    8'h0C
`define CTM_OFS_CMP_LO    8'h10
`define CTM_OFS_CMP_HI    8'h14
`define CTM_OFS_PIN_SEL   8'h18
`define CTM_OFS_INT_STAT  8'h1C
`define CTM_OFS_INT_MASK  8'h20
`define CTM_OFS_OUT_INV   8'h24

// ----------------------------------------------------------------
// Control register 0 fields
// ----------------------------------------------------------------
`define CTM_C0_PAUSE      7
`define CTM_C0_CKSEL_HI   6
`define CTM_C0_CKSEL_LO   4
`define CTM_C0_ON         3
`define CTM_C0_PER_HI     2
`define CTM_C0_PER_LO     0

// ----------------------------------------------------------------
// Control register 1 fields
// ----------------------------------------------------------------
`define CTM_C1_MODE_HI    7
`define CTM_C1_MODE_LO    6
`define CTM_C1_IO_HI      5
`define CTM_C1_IO_LO      4
`define CTM_C1_OC         3
`define CTM_C1_POL        2
`define CTM_C1_DPX        1
`define CTM_C1_CCLR       0

// ----------------------------------------------------------------
// Modes, output actions and clock selections
// ----------------------------------------------------------------
`define CTM_MODE_CMP      2'h0
`define CTM_MODE_PWM      2'h2
`define CTM_MODE_TMR      2'h3
`define CTM_IO_NONE       2'h0
`define CTM_IO_LOW        2'h1
`define CTM_IO_HIGH       2'h2
`define CTM_IO_TOGGLE     2'h3
`define CTM_CK_SYS4       3'h0
`define CTM_CK_SYS        3'h1
`define CTM_CK_H16        3'h2
`define CTM_CK_H64        3'h3
`define CTM_CK_TBC        3'h4
`define CTM_CK_OFF        3'h5
`define CTM_CK_PIN_RISE   3'h6
`define CTM_CK_PIN_FALL   3'h7

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define CTM_INT_CMP       0
`define CTM_INT_PER       1

// ----------------------------------------------------------------
// Reset values and pin-select variants
// ----------------------------------------------------------------
`define CTM_CTRL_RST      8'h00
`define CTM_CMP_RST       10'h000
`define CTM_PSEL_MASK_S   8'h30
`define CTM_PSEL_RST_S    8'h10
`define CTM_PSEL_MASK_M   8'h33
`define CTM_PSEL_RST_M    8'h11
`define CTM_PSEL_MASK_F   8'hF3
`define CTM_PSEL_RST_F    8'h93

// ----------------------------------------------------------------
// Divider counts and counter geometry
// ----------------------------------------------------------------
`define CTM_DIV_SYS4      4
`define CTM_DIV_H16       16
`define CTM_DIV_H64       64
`define CTM_CNT_MAX       10'h3FF
`define CTM_PER_STEP      7

`endif

/* File: design/ctm_timer.v */
/*
 * Compact 10-bit timer with pin-select register, Wishbone slave.
 * Assumes synchronous pin inputs, one clock, high clock equal to clk_i.
 */
// Design decisions made here: the register offsets and register access over Wishbone.
// Behaviour
// - Set pin-select bit routes its pin to the timer, clear keeps other use.
// - Unimplemented pin-select bits ignore writes and read as zero.
// - Port data bits optionally invert the timer output on each pin.
// - High bytes accessed directly; low bytes through one 8-bit buffer.
// - Low compare write fills buffer; high write copies buffer to low byte.
// - High byte read latches low byte into buffer; low read returns buffer.
// - A 10-bit up-counter advances on each selected clock tick.
// - Period compares all ten bits of the next count with per x 128; duty compares all ten.
// - No counter write path; cleared on timer-on rising edge, on the clear event or on overflow.
// - Overflow, or period match (compare match if CCLR set), clears counter and raises interrupt.
// - Modes: compare match output, timer/event counter, PWM output.
// - One external clock input, two outputs, equal or inverted.
// - Counter is a read-only pair; duty compare is a read/write pair.
// - Two control registers hold mode, control and period bits.
// - Clock select: sys/4, sys, high/16, high/64, base, pin edges; 101 off.
// - Period matches every per x 128 ticks; period zero runs to overflow.
`timescale 1ns/10ps
`default_nettype none
`include "ctm_defs.vh"

module ctm_timer #(
   parameter [1:0] PSEL_VARIANT = 2'h2
) (
   // System
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output wire ack_o,
   // Clock sources
   input wire tbc_tick_i,
   input wire timer0_ext_clock_pin_i,
   // Shared output pins: other function
   input wire [1:0] alt_out_i,
   input wire [1:0] alt_oe_i,
   // Shared output pins
   output wire timer0_output_pin0_o,
   output wire timer0_output_pin0_oe_o,
   output wire timer0_output_pin1_o,
   output wire timer0_output_pin1_oe_o,
   // Pin enables for the second timer's pins
   output wire [3:0] timer1_pin_en_o,
   // Interrupt
   output wire irq_o
);

   // ----------------------------------------------------------------
   // Pin-select variant
   // ----------------------------------------------------------------
   localparam [7:0] PSEL_MASK = (PSEL_VARIANT == 2'h0) ? `CTM_PSEL_MASK_S :
      (PSEL_VARIANT == 2'h1) ? `CTM_PSEL_MASK_M : `CTM_PSEL_MASK_F;
   localparam [7:0] PSEL_RST = (PSEL_VARIANT == 2'h0) ? `CTM_PSEL_RST_S :
      (PSEL_VARIANT == 2'h1) ? `CTM_PSEL_RST_M : `CTM_PSEL_RST_F;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg [7:0] ctrl0_q;
   reg [7:0] ctrl1_q;
   reg [9:0] duty_q;
   reg [7:0] lo_buf_q;
   reg [7:0] pin_sel_q;
   reg [1:0] int_stat_q;
   reg [1:0] int_mask_q;
   reg [1:0] out_inv_q;
   reg ack_q;
   reg [9:0] cnt_q;
   reg on_q;
   reg tout_q;
   reg pin_q;
   reg [5:0] div_q;

   wire [2:0] ck_sel = ctrl0_q[`CTM_C0_CKSEL_HI:`CTM_C0_CKSEL_LO];
   wire [2:0] per = ctrl0_q[`CTM_C0_PER_HI:`CTM_C0_PER_LO];
   wire [1:0] mode = ctrl1_q[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
   wire [1:0] io = ctrl1_q[`CTM_C1_IO_HI:`CTM_C1_IO_LO];
   wire oc = ctrl1_q[`CTM_C1_OC];
   wire timer_on = ctrl0_q[`CTM_C0_ON];

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire acc = cyc_i & stb_i & ~ack_q;
   wire wr = acc & we_i & sel_i[0];
   wire rd = acc & ~we_i;
   wire hit_c0 = adr_i == `CTM_OFS_CTRL0;
   wire hit_c1 = adr_i == `CTM_OFS_CTRL1;
   wire hit_cl = adr_i == `CTM_OFS_CNT_LO;
   wire hit_ch = adr_i == `CTM_OFS_CNT_HI;
   wire hit_al = adr_i == `CTM_OFS_CMP_LO;
   wire hit_ah = adr_i == `CTM_OFS_CMP_HI;
   wire hit_ps = adr_i == `CTM_OFS_PIN_SEL;
   wire hit_is = adr_i == `CTM_OFS_INT_STAT;
   wire hit_im = adr_i == `CTM_OFS_INT_MASK;
   wire hit_oi = adr_i == `CTM_OFS_OUT_INV;

   assign ack_o = ack_q;

   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc;
      end
   end

   // ----------------------------------------------------------------
   // Clock source selection
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= 6'h00;
         pin_q <= 1'b0;
      end else begin
         div_q <= div_q + 6'h01;
         pin_q <= timer0_ext_clock_pin_i;
      end
   end

   reg tick;
   always @* begin
      tick = 1'b0;
      case (ck_sel)
         `CTM_CK_SYS4: tick = div_q[1:0] == 2'h3;
         `CTM_CK_SYS: tick = 1'b1;
         `CTM_CK_H16: tick = div_q[3:0] == 4'hF;
         `CTM_CK_H64: tick = div_q == 6'h3F;
         `CTM_CK_TBC: tick = tbc_tick_i;
         `CTM_CK_OFF: tick = 1'b0;
         `CTM_CK_PIN_RISE: tick = timer0_ext_clock_pin_i & ~pin_q;
         `CTM_CK_PIN_FALL: tick = ~timer0_ext_clock_pin_i & pin_q;
         default: tick = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Counter and comparators
   // ----------------------------------------------------------------
   wire run = timer_on & ~ctrl0_q[`CTM_C0_PAUSE] & tick;
   wire on_rise = timer_on & ~on_q;
   wire [9:0] cnt_nx = cnt_q + 10'h001;
   wire per_hit = (per == 3'h0) ? (cnt_q == `CTM_CNT_MAX) :
      (cnt_nx == {per, 7'h00});
   wire cmp_hit = (duty_q == 10'h000) ? (cnt_q == `CTM_CNT_MAX) :
      (cnt_nx == duty_q);
   wire per_ev = run & per_hit;
   wire cmp_ev = run & cmp_hit;
   wire clr_ev = ctrl1_q[`CTM_C1_CCLR] ? cmp_ev : per_ev;

   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 10'h000;
         on_q <= 1'b0;
      end else begin
         on_q <= timer_on;
         if (on_rise) begin
            cnt_q <= 10'h000;
         end else if (clr_ev | (run & cnt_q == `CTM_CNT_MAX)) begin
            cnt_q <= 10'h000;
         end else if (run) begin
            cnt_q <= cnt_nx;
         end
      end
   end

   // ----------------------------------------------------------------
   // Output waveform
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         tout_q <= 1'b0;
      end else if (mode == `CTM_MODE_CMP) begin
         if (on_rise) begin
            tout_q <= oc;
         end else if (cmp_ev) begin
            case (io)
               `CTM_IO_LOW: tout_q <= 1'b0;
               `CTM_IO_HIGH: tout_q <= 1'b1;
               `CTM_IO_TOGGLE: tout_q <= ~tout_q;
               default: tout_q <= tout_q;
            endcase
         end
      end else if (mode == `CTM_MODE_PWM) begin
         case (io)
            `CTM_IO_NONE: tout_q <= ~oc;
            `CTM_IO_LOW: tout_q <= oc;
            `CTM_IO_HIGH: tout_q <= (cnt_q < duty_q) ? oc : ~oc;
            default: tout_q <= tout_q;
         endcase
      end
   end

   wire tout = tout_q ^ ctrl1_q[`CTM_C1_POL];
   wire pin_en0 = pin_sel_q[0];
   wire pin_en1 = pin_sel_q[1];

   assign timer0_output_pin0_o = pin_en0 ? (tout ^ out_inv_q[0]) :
      alt_out_i[0];
   assign timer0_output_pin1_o = pin_en1 ? (tout ^ out_inv_q[1]) :
      alt_out_i[1];
   assign timer0_output_pin0_oe_o = pin_en0 | alt_oe_i[0];
   assign timer0_output_pin1_oe_o = pin_en1 | alt_oe_i[1];
   assign timer1_pin_en_o = pin_sel_q[7:4];

   // ----------------------------------------------------------------
   // Register writes and buffered pair access
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl0_q <= `CTM_CTRL_RST;
         ctrl1_q <= `CTM_CTRL_RST;
         duty_q <= `CTM_CMP_RST;
         lo_buf_q <= 8'h00;
         pin_sel_q <= PSEL_RST;
         int_mask_q <= 2'h0;
         out_inv_q <= 2'h0;
      end else begin
         if (wr & hit_c0) begin
            ctrl0_q <= dat_i[7:0];
         end
         if (wr & hit_c1) begin
            ctrl1_q <= dat_i[7:0];
         end
         if (wr & hit_al) begin
            lo_buf_q <= dat_i[7:0];
         end
         if (wr & hit_ah) begin
            duty_q <= {dat_i[1:0], lo_buf_q};
         end
         if (rd & hit_ch) begin
            lo_buf_q <= cnt_q[7:0];
         end
         if (rd & hit_ah) begin
            lo_buf_q <= duty_q[7:0];
         end
         if (wr & hit_ps) begin
            pin_sel_q <= dat_i[7:0] & PSEL_MASK;
         end
         if (wr & hit_im) begin
            int_mask_q <= dat_i[1:0];
         end
         if (wr & hit_oi) begin
            out_inv_q <= dat_i[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status, set wins over write-one clear
   // ----------------------------------------------------------------
   wire [1:0] int_clr = (wr & hit_is) ? dat_i[1:0] : 2'h0;
   wire [1:0] int_set = {per_ev, cmp_ev};

   always @(posedge clk_i) begin
      if (rst_i) begin
         int_stat_q <= 2'h0;
      end else begin
         int_stat_q <= (int_stat_q & ~int_clr) | int_set;
      end
   end

   assign irq_o = |(int_stat_q & int_mask_q);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   reg [7:0] rd_val;
   always @* begin
      rd_val = 8'h00;
      case (adr_i)
         `CTM_OFS_CTRL0: rd_val = ctrl0_q;
         `CTM_OFS_CTRL1: rd_val = ctrl1_q;
         `CTM_OFS_CNT_LO: rd_val = lo_buf_q;
         `CTM_OFS_CNT_HI: rd_val = {6'h00, cnt_q[9:8]};
         `CTM_OFS_CMP_LO: rd_val = lo_buf_q;
         `CTM_OFS_CMP_HI: rd_val = {6'h00, duty_q[9:8]};
         `CTM_OFS_PIN_SEL: rd_val = pin_sel_q & PSEL_MASK;
         `CTM_OFS_INT_STAT: rd_val = {6'h00, int_stat_q};
         `CTM_OFS_INT_MASK: rd_val = {6'h00, int_mask_q};
         `CTM_OFS_OUT_INV: rd_val = {6'h00, out_inv_q};
         default: rd_val = 8'h00;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h00000000;
      end else if (rd) begin
         dat_o <= {24'h000000, rd_val};
      end
   end

endmodule // ctm_timer
`default_nettype wire
